//--- verilog/lvo_pkg.sv
// Purpose: shared constants for the undervolt control and option word block
// Assumes: option word delivered by the programmer on a static 32-bit port
// Notes: bus offsets are byte addresses on a 32-bit classic bus
`default_nettype none
package lvo_pkg;
	// ----------------------------------------------------------------
	// bus
	// ----------------------------------------------------------------
	localparam int ADR_W = 4;
	localparam int DAT_W = 32;
	localparam logic [ADR_W-1:0] OFS_SYS_CTRL_ZERO = 4'h0;
	localparam logic [ADR_W-1:0] OFS_OPTION_VIEW = 4'h4;
	localparam logic [DAT_W-1:0] DATA_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// system_control_zero fields
	// ----------------------------------------------------------------
	localparam int CTL_W = 8;
	localparam int BIT_UV_ENABLE = 0;
	localparam int BIT_UV_FLAG = 1;
	localparam int BIT_PCLK_PRESCALE = 3;
	localparam int BIT_T0_EXT_CLK = 6;
	localparam int BIT_CMP2_INVERT = 7;
	localparam logic [CTL_W-1:0] CTL_WRITE_MASK = 8'hC9;
	localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// option word layout
	// ----------------------------------------------------------------
	localparam int OPT_W = 32;
	localparam int OPT_WAKE_LO = 0;
	localparam int OPT_WAKE_W = 8;
	localparam int OPT_PB2_CUR_OFF = 8;
	localparam int OPT_PB1_PCLK = 9;
	localparam int OPT_PG_ACT_LOW = 10;
	localparam int OPT_PG_ASYNC = 11;
	localparam int OPT_CMP0_EN = 12;
	localparam int OPT_CMP1_EN = 13;
	localparam int OPT_CMP1_DEB = 14;
	localparam int OPT_CMP2_MODE_LO = 15;
	localparam int OPT_CMP2_DEB = 17;
	localparam int OPT_CMP3_DEB = 18;
	localparam int OPT_V18_ADC = 19;
	localparam int OPT_V0C_UV = 20;
	localparam int OPT_WD_EN = 21;
	localparam int OPT_WD_PERIOD_LO = 22;
	localparam int OPT_WD_FSYS4 = 24;
	localparam int OPT_WD_TWO_CLR = 25;
	localparam int OPT_UV_EN = 26;
	localparam logic [OPT_W-1:0] OPT_USED_MASK = 32'h07FF_FFFF;

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	localparam int WD_EXP_MAX = 16;
	localparam int WD_CNT_W = WD_EXP_MAX + 1;
	localparam int WD_FSYS_DIV = 4;
	localparam int WD_DIV_W = 2;
	localparam logic [WD_DIV_W-1:0] WD_DIV_LAST = 2'(WD_FSYS_DIV - 1);
endpackage
`default_nettype wire

//--- verilog/lvo_wd_if.sv
// Purpose: settings and events between the control top and the watchdog
// Assumes: one clock domain
// Notes: none
`default_nettype none
interface lvo_wd_if;
	logic enable;
	logic [1:0] period_sel;
	logic fsys_div4;
	logic two_clear;
	logic slow_tick;
	logic clear_a;
	logic clear_b;
	logic timeout;
	modport ctrl (output enable, output period_sel, output fsys_div4, output two_clear,
		output slow_tick, output clear_a, output clear_b, input timeout);
	modport wd (input enable, input period_sel, input fsys_div4, input two_clear,
		input slow_tick, input clear_a, input clear_b, output timeout);
endinterface
`default_nettype wire

//--- verilog/lvo_watchdog.sv
// Purpose: watchdog counter with option-selected period, clock and clearing
// Assumes: slow_tick is a one-cycle pulse per low-speed oscillator period
// Notes: timeout is a one-cycle pulse; the count restarts after it
`default_nettype none
module lvo_watchdog
	import lvo_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	lvo_wd_if.wd wdp
);
	logic [WD_DIV_W-1:0] div_reg;
	logic [WD_CNT_W-1:0] cnt_reg;
	logic arm_a_reg;
	logic arm_b_reg;
	logic timeout_reg;
	logic tick;
	logic do_clear;
	logic at_limit;

	function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [1:0] sel);
		wd_limit = WD_CNT_W'(1) << (WD_EXP_MAX - int'(sel));
	endfunction

	assign tick = wdp.fsys_div4 ? (div_reg == WD_DIV_LAST) : wdp.slow_tick;

	assign do_clear = wdp.two_clear ?
		((arm_a_reg | wdp.clear_a) & (arm_b_reg | wdp.clear_b)) :
		(wdp.clear_a | wdp.clear_b);

	assign at_limit = tick && (cnt_reg == wd_limit(wdp.period_sel) - WD_CNT_W'(1));

	always_ff @(posedge clk)
	begin
		if (rst)
			div_reg <= '0;
		else
			div_reg <= div_reg + WD_DIV_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (rst || do_clear || !wdp.two_clear)
		begin
			arm_a_reg <= 1'b0;
			arm_b_reg <= 1'b0;
		end
		else
		begin
			arm_a_reg <= arm_a_reg | wdp.clear_a;
			arm_b_reg <= arm_b_reg | wdp.clear_b;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || !wdp.enable || do_clear || at_limit)
			cnt_reg <= '0;
		else if (tick)
			cnt_reg <= cnt_reg + WD_CNT_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			timeout_reg <= 1'b0;
		else
			timeout_reg <= wdp.enable && !do_clear && at_limit;
	end

	assign wdp.timeout = timeout_reg;
endmodule
`default_nettype wire

//--- verilog/lvo_ctrl_top.sv
// Purpose: option word holder and undervolt detector control register
// Assumes: all inputs synchronous to REF_CLK; SRST doubles as power-on reset
// Notes: option word is captured while SRST is high and then frozen
//
// How it works
// - undervolt unit needs its option enabled
// - bit 0 switches detector off/on, read/write
// - bit 1 shows low supply, read only
// - power-down forces detector off
// - bits 5, 4, 2 read zero
// - software cannot change options
// - option picks vector 0C source
// - option picks vector 18 source
// - watchdog option enables or disables it
// - watchdog period 2^16 down to 2^13
// - watchdog clock: slow osc or fsys/4
// - watchdog cleared by one or two instructions
// - pulse generator polarity from option
// - pulse generator start synchronised or not
// - per-pin port A wake-up enable
// - comparator 2 off or three input pairings
// - comparator enables and debounce options
// - undervolt raises an interrupt request
`default_nettype none
module lvo_ctrl_top
	import lvo_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [lvo_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [lvo_pkg::DAT_W-1:0] WB_DAT_I,
	output logic [lvo_pkg::DAT_W-1:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [lvo_pkg::OPT_W-1:0] OPTION_WORD,
	input wire logic POWER_DOWN,
	input wire logic SUPPLY_LOW,
	input wire logic EXT_INT_REQ,
	input wire logic TIMER_TWO_INT_REQ,
	input wire logic ADC_INT_REQ,
	output logic VEC_0C_REQ,
	output logic VEC_18_REQ,
	output logic UNDERVOLT_INT_REQ,
	input wire logic LOW_SPEED_OSC_TICK,
	input wire logic WATCHDOG_CLEAR_A,
	input wire logic WATCHDOG_CLEAR_B,
	output logic WATCHDOG_TIMEOUT,
	input wire logic PULSE_GEN_RAW,
	input wire logic PULSE_GEN_START_IN,
	output logic PULSE_GEN_OUT,
	output logic PULSE_GEN_START,
	input wire logic [7:0] PORT_A_ACTIVITY,
	output logic [7:0] PORT_A_WAKE_EN,
	output logic WAKE_REQ,
	output logic PB2_IS_CURRENT_OFF_INPUT,
	output logic PB1_IS_PERIPH_CLK_OUT,
	output logic CMP_ZERO_ENABLE,
	output logic CMP_ONE_ENABLE,
	output logic [1:0] CMP_TWO_MODE,
	output logic [2:0] CMP_DEBOUNCE_EN,
	output logic CMP_TWO_INVERT,
	output logic TIMER_ZERO_EXT_CLK_SEL,
	output logic PERIPH_CLK_PRESCALE,
	output logic UNDERVOLT_ACTIVE
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [OPT_W-1:0] opt_reg;
	logic [CTL_W-1:0] ctl_reg;
	logic [CTL_W-1:0] ctl_next;
	logic uv_flag_reg;
	logic uv_flag_next;
	logic uv_int_reg;
	logic ack_reg;
	logic [DAT_W-1:0] rdata_reg;
	logic [DAT_W-1:0] rdata_next;
	logic vec0c_reg;
	logic vec18_reg;
	logic pg_out_reg;
	logic pg_start_reg;
	logic wake_reg;
	logic req;
	logic wr_take;
	logic uv_active;
	logic [CTL_W-1:0] ctl_view;

	lvo_wd_if wd_bus ();

	function automatic logic opt_bit(input logic [OPT_W-1:0] w, input int pos);
		opt_bit = w[pos];
	endfunction

	// ----------------------------------------------------------------
	// option word
	// ----------------------------------------------------------------
	// capture during reset
	// held from then on; nothing on the bus can reach it
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			opt_reg <= OPTION_WORD & OPT_USED_MASK;
	end

	assign PORT_A_WAKE_EN = opt_reg[OPT_WAKE_LO +: OPT_WAKE_W];
	assign PB2_IS_CURRENT_OFF_INPUT = opt_bit(opt_reg, OPT_PB2_CUR_OFF);
	assign PB1_IS_PERIPH_CLK_OUT = opt_bit(opt_reg, OPT_PB1_PCLK);
	assign CMP_ZERO_ENABLE = opt_bit(opt_reg, OPT_CMP0_EN);
	assign CMP_ONE_ENABLE = opt_bit(opt_reg, OPT_CMP1_EN);
	assign CMP_TWO_MODE = opt_reg[OPT_CMP2_MODE_LO +: 2];
	assign CMP_DEBOUNCE_EN = {opt_bit(opt_reg, OPT_CMP3_DEB), opt_bit(opt_reg, OPT_CMP2_DEB),
		opt_bit(opt_reg, OPT_CMP1_DEB)};

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	assign req = WB_CYC_I & WB_STB_I;
	// write lands on the edge where ack is seen by the master
	assign wr_take = req & WB_WE_I & ack_reg & WB_SEL_I[0];

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			ack_reg <= 1'b0;
		else
			ack_reg <= req & ~ack_reg;
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	// enable bit writable
	always_comb
	begin
		ctl_next = ctl_reg;
		if (wr_take && WB_ADR_I == OFS_SYS_CTRL_ZERO)
			ctl_next = WB_DAT_I[CTL_W-1:0] & CTL_WRITE_MASK;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			ctl_reg <= CTL_RESET;
		else
			ctl_reg <= ctl_next;
	end

	assign CMP_TWO_INVERT = ctl_reg[BIT_CMP2_INVERT];
	assign TIMER_ZERO_EXT_CLK_SEL = ctl_reg[BIT_T0_EXT_CLK];
	assign PERIPH_CLK_PRESCALE = ctl_reg[BIT_PCLK_PRESCALE];

	// ----------------------------------------------------------------
	// undervolt detector
	// ----------------------------------------------------------------
	// option gates the unit
	assign uv_active = opt_bit(opt_reg, OPT_UV_EN) & ctl_reg[BIT_UV_ENABLE] & ~POWER_DOWN;
	assign UNDERVOLT_ACTIVE = uv_active;

	// flag follows supply
	// the flag is a live status, not sticky: it drops when supply recovers
	assign uv_flag_next = uv_active & SUPPLY_LOW;

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			uv_flag_reg <= 1'b0;
		else
			uv_flag_reg <= uv_flag_next;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			uv_int_reg <= 1'b0;
		else
			uv_int_reg <= uv_flag_next & ~uv_flag_reg;
	end

	assign UNDERVOLT_INT_REQ = uv_int_reg;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// unimplemented bits read zero
	always_comb
	begin
		ctl_view = ctl_reg & CTL_WRITE_MASK;
		ctl_view[BIT_UV_FLAG] = uv_flag_reg;
	end

	always_comb
	begin
		rdata_next = DATA_ZERO;
		if (WB_ADR_I == OFS_SYS_CTRL_ZERO)
			rdata_next = {{(DAT_W-CTL_W){1'b0}}, ctl_view};
		else if (WB_ADR_I == OFS_OPTION_VIEW)
			rdata_next = opt_reg;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			rdata_reg <= DATA_ZERO;
		else if (req & ~ack_reg & ~WB_WE_I)
			rdata_reg <= rdata_next;
	end

	assign WB_DAT_O = rdata_reg;
	assign WB_ACK_O = ack_reg;

	// ----------------------------------------------------------------
	// interrupt vector routing
	// ----------------------------------------------------------------
	// vector 0C source
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			vec0c_reg <= 1'b0;
		else
			vec0c_reg <= opt_bit(opt_reg, OPT_V0C_UV) ? (uv_flag_next & ~uv_flag_reg) : EXT_INT_REQ;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			vec18_reg <= 1'b0;
		else
			vec18_reg <= opt_bit(opt_reg, OPT_V18_ADC) ? ADC_INT_REQ : TIMER_TWO_INT_REQ;
	end

	assign VEC_0C_REQ = vec0c_reg;
	assign VEC_18_REQ = vec18_reg;

	// ----------------------------------------------------------------
	// pulse generator
	// ----------------------------------------------------------------
	// output polarity
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			pg_out_reg <= 1'b0;
		else
			pg_out_reg <= PULSE_GEN_RAW ^ opt_bit(opt_reg, OPT_PG_ACT_LOW);
	end

	assign PULSE_GEN_OUT = pg_out_reg;

	// start sync or not
	// the async path is a combinational pass-through, one cycle earlier
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			pg_start_reg <= 1'b0;
		else
			pg_start_reg <= PULSE_GEN_START_IN;
	end

	assign PULSE_GEN_START = opt_bit(opt_reg, OPT_PG_ASYNC) ? PULSE_GEN_START_IN : pg_start_reg;

	// ----------------------------------------------------------------
	// wake-up
	// ----------------------------------------------------------------
	// only enabled pins wake
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			wake_reg <= 1'b0;
		else
			wake_reg <= POWER_DOWN & |(PORT_A_ACTIVITY & PORT_A_WAKE_EN);
	end

	assign WAKE_REQ = wake_reg;

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	// enable from option
	assign wd_bus.enable = opt_bit(opt_reg, OPT_WD_EN);
	assign wd_bus.period_sel = opt_reg[OPT_WD_PERIOD_LO +: 2];
	assign wd_bus.fsys_div4 = opt_bit(opt_reg, OPT_WD_FSYS4);
	assign wd_bus.two_clear = opt_bit(opt_reg, OPT_WD_TWO_CLR);
	assign wd_bus.slow_tick = LOW_SPEED_OSC_TICK;
	assign wd_bus.clear_a = WATCHDOG_CLEAR_A;
	assign wd_bus.clear_b = WATCHDOG_CLEAR_B;

	lvo_watchdog u_watchdog (
		.clk(REF_CLK),
		.rst(SRST),
		.wdp(wd_bus.wd)
	);

	assign WATCHDOG_TIMEOUT = wd_bus.timeout;
endmodule
`default_nettype wire

//--- dv/lvo_ctrl_top_sva.sv
// Purpose: port-level checks for lvo_ctrl_top
// Assumes: OPTION_WORD is only trusted while SRST is high
// Notes: keeps its own snapshot of the option word
`default_nettype none
module lvo_ctrl_top_sva
	import lvo_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [lvo_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [lvo_pkg::DAT_W-1:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic [lvo_pkg::OPT_W-1:0] OPTION_WORD,
	input wire logic POWER_DOWN,
	input wire logic EXT_INT_REQ,
	input wire logic TIMER_TWO_INT_REQ,
	input wire logic ADC_INT_REQ,
	input wire logic VEC_0C_REQ,
	input wire logic VEC_18_REQ,
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic PULSE_GEN_RAW,
	input wire logic PULSE_GEN_OUT,
	input wire logic [1:0] CMP_TWO_MODE,
	input wire logic UNDERVOLT_ACTIVE
);
	logic [OPT_W-1:0] opt_q;
	// snapshot, so later pin changes cannot mask a leak
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			opt_q <= OPTION_WORD;
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held too long");
	property p_ack_take;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
	endproperty
	a_ack_take: assert property (p_ack_take)
		else $error("request not answered");
	property p_rd_zero;
		WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_SYS_CTRL_ZERO |-> WB_DAT_O[31:8] == 24'h00_0000 && WB_DAT_O[5:4] == 2'h0
			&& !WB_DAT_O[2];
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("unused control bit reads one");
	property p_pd_off;
		POWER_DOWN |-> !UNDERVOLT_ACTIVE;
	endproperty
	a_pd_off: assert property (p_pd_off)
		else $error("detector on in power-down");
	property p_opt_off;
		!opt_q[OPT_UV_EN] |-> !UNDERVOLT_ACTIVE;
	endproperty
	a_opt_off: assert property (p_opt_off)
		else $error("detector on with option off");
	property p_v0c;
		!opt_q[OPT_V0C_UV] && !$past(SRST) |-> VEC_0C_REQ == $past(EXT_INT_REQ);
	endproperty
	a_v0c: assert property (p_v0c)
		else $error("vector 0C source wrong");
	property p_v18;
		!$past(SRST) |-> VEC_18_REQ == $past(opt_q[OPT_V18_ADC] ? ADC_INT_REQ : TIMER_TWO_INT_REQ);
	endproperty
	a_v18: assert property (p_v18)
		else $error("vector 18 source wrong");
	property p_pg;
		!$past(SRST) |-> PULSE_GEN_OUT == $past(PULSE_GEN_RAW ^ opt_q[OPT_PG_ACT_LOW]);
	endproperty
	a_pg: assert property (p_pg)
		else $error("pulse polarity wrong");
	property p_wd_off;
		!opt_q[OPT_WD_EN] |-> !WATCHDOG_TIMEOUT;
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("disabled watchdog fired");
	property p_opt_hold;
		CMP_TWO_MODE == opt_q[OPT_CMP2_MODE_LO+1:OPT_CMP2_MODE_LO];
	endproperty
	a_opt_hold: assert property (p_opt_hold)
		else $error("option output drifted");
	c_wr: cover property (WB_ACK_O && WB_WE_I);
	c_wd: cover property (WATCHDOG_TIMEOUT);
	c_v0c: cover property (VEC_0C_REQ && opt_q[OPT_V0C_UV]);
endmodule
bind lvo_ctrl_top lvo_ctrl_top_sva u_sva (.REF_CLK(REF_CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
	.WB_ACK_O(WB_ACK_O), .OPTION_WORD(OPTION_WORD), .POWER_DOWN(POWER_DOWN), .EXT_INT_REQ(EXT_INT_REQ),
	.TIMER_TWO_INT_REQ(TIMER_TWO_INT_REQ), .ADC_INT_REQ(ADC_INT_REQ), .VEC_0C_REQ(VEC_0C_REQ),
	.VEC_18_REQ(VEC_18_REQ), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .PULSE_GEN_RAW(PULSE_GEN_RAW),
	.PULSE_GEN_OUT(PULSE_GEN_OUT), .CMP_TWO_MODE(CMP_TWO_MODE), .UNDERVOLT_ACTIVE(UNDERVOLT_ACTIVE));
`default_nettype wire

//--- dv/lvo_ctrl_top_test.sv
// Purpose: self-checking bench for lvo_ctrl_top
// Assumes: options take effect only under reset
// Notes: watchdog run on its shortest period
`default_nettype none
module lvo_ctrl_top_test;
	import lvo_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, pd = 0, low = 0, ext = 0, t2 = 0, adc = 0;
	logic tick = 0, ca = 0, cb = 0, raw = 0, sti = 0;
	logic [3:0] adr = 4'h0, sel = 4'hF;
	logic [7:0] act = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, opt = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack, v0c, v18, uvi, wto, pgo, pgs, wake, pb2, pb1, c0, c1, c2i, t0s, pcs, uva;
	logic [1:0] mode;
	logic [2:0] deb;
	logic [7:0] wen;
	int fail_count = 0, checked = 0, cyc_n = 0;
	lvo_ctrl_top uut (.REF_CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.OPTION_WORD(opt), .POWER_DOWN(pd), .SUPPLY_LOW(low), .EXT_INT_REQ(ext), .TIMER_TWO_INT_REQ(t2),
		.ADC_INT_REQ(adc), .VEC_0C_REQ(v0c), .VEC_18_REQ(v18), .UNDERVOLT_INT_REQ(uvi),
		.LOW_SPEED_OSC_TICK(tick), .WATCHDOG_CLEAR_A(ca), .WATCHDOG_CLEAR_B(cb), .WATCHDOG_TIMEOUT(wto),
		.PULSE_GEN_RAW(raw), .PULSE_GEN_START_IN(sti), .PULSE_GEN_OUT(pgo), .PULSE_GEN_START(pgs),
		.PORT_A_ACTIVITY(act), .PORT_A_WAKE_EN(wen), .WAKE_REQ(wake), .PB2_IS_CURRENT_OFF_INPUT(pb2),
		.PB1_IS_PERIPH_CLK_OUT(pb1), .CMP_ZERO_ENABLE(c0), .CMP_ONE_ENABLE(c1), .CMP_TWO_MODE(mode),
		.CMP_DEBOUNCE_EN(deb), .CMP_TWO_INVERT(c2i), .TIMER_ZERO_EXT_CLK_SEL(t0s), .PERIPH_CLK_PRESCALE(pcs),
		.UNDERVOLT_ACTIVE(uva));
	always #50 clk = ~clk;
	// slow tick every other cycle keeps the watchdog run short
	always @(posedge clk) tick <= ~tick;
	always @(posedge clk)
	begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 99000)
		begin
			fail_count++;
			results();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rst(input logic [31:0] o);
		@(posedge clk);
		srst <= 1;
		opt <= o;
		repeat (4) @(posedge clk);
		srst <= 0;
		@(posedge clk);
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(negedge clk);
		while (ack !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		chk("ack", 1, ack);
		@(posedge clk);
		q = rdat;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic gap(output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (wto !== 1'b1 && n < 40000);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reg;
		logic [31:0] q;
		rst(32'h0400_0000);
		wb(0, OFS_SYS_CTRL_ZERO, 32'h0000_0000, q);
		chk("ctl_por", 32'h0000_0000, q);
		wb(1, OFS_SYS_CTRL_ZERO, 32'hFFFF_FFFF, q);
		wb(0, OFS_SYS_CTRL_ZERO, 32'h0000_0000, q);
		chk("ctl_ones", 32'h0000_00C9, q);
		chk("ctl_outs_on", 32'h0000_0007, {29'h0, c2i, t0s, pcs});
		wb(1, OFS_SYS_CTRL_ZERO, 32'h0000_0036, q);
		wb(0, OFS_SYS_CTRL_ZERO, 32'h0000_0000, q);
		chk("ctl_off", 32'h0000_0000, q);
		chk("ctl_outs_off", 32'h0000_0000, {29'h0, c2i, t0s, pcs});
		wb(1, OFS_OPTION_VIEW, 32'hFFFF_FFFF, q);
		wb(0, OFS_OPTION_VIEW, 32'h0000_0000, q);
		chk("opt_view", 32'h0400_0000, q);
		wb(0, 4'h8, 32'h0000_0000, q);
		chk("unmapped", 32'h0000_0000, q);
		opt <= 32'h0000_00FF;
		repeat (2) @(posedge clk);
		chk("wake_en_hold", 32'h0000_0000, {24'h00_0000, wen});
		$display("t_reg done");
	endtask
	task automatic t_uv;
		logic [31:0] q;
		int n0, n1;
		n0 = 0;
		n1 = 0;
		rst(32'h0410_0000);
		ext <= 1;
		wb(1, OFS_SYS_CTRL_ZERO, 32'h0000_0001, q);
		low <= 1;
		repeat (6)
		begin
			@(negedge clk);
			n0 += v0c;
			n1 += uvi;
		end
		chk("uv_irq", 1, n1);
		chk("vec0c", 1, n0);
		wb(0, OFS_SYS_CTRL_ZERO, 32'h0000_0000, q);
		chk("flag_low", 32'h0000_0003, q);
		chk("uv_active", 1, uva);
		pd <= 1;
		wb(0, OFS_SYS_CTRL_ZERO, 32'h0000_0000, q);
		chk("flag_pd", 32'h0000_0001, q);
		chk("uv_active_pd", 0, uva);
		ext <= 0;
		pd <= 0;
		rst(32'h0000_0000);
		wb(1, OFS_SYS_CTRL_ZERO, 32'h0000_0001, q);
		wb(0, OFS_SYS_CTRL_ZERO, 32'h0000_0000, q);
		chk("flag_opt_off", 32'h0000_0001, q);
		low <= 0;
		$display("t_uv done");
	endtask
	task automatic t_opt;
		for (int i = 0; i < 4; i++)
		begin
			rst(32'h0000_005A | (i << 15) | (i[0] ? 32'h000E_7F00 : 32'h0000_0000));
			t2 <= i[1];
			adc <= ~i[1];
			raw <= 1;
			pd <= 1;
			act <= i[1] ? 8'hA5 : 8'h0F;
			repeat (2) @(posedge clk);
			sti <= 1;
			@(negedge clk);
			chk("pg_start", i[0], pgs);
			chk("cmp2_mode", i, mode);
			chk("vec18", i[0] ^ i[1], v18);
			chk("pg_out", !i[0], pgo);
			chk("wake", !i[1], wake);
			chk("wake_en", 32'h0000_005A, wen);
			chk("pins", {2{i[0]}}, {pb2, pb1});
			chk("cmps", {5{i[0]}}, {c0, c1, deb});
			@(posedge clk);
			sti <= 0;
			pd <= 0;
		end
		$display("t_opt done");
	endtask
	task automatic t_wd;
		int n, m;
		act <= 8'h00;
		// fsys/4 source: one tick per four clocks
		rst(32'h03E0_0000);
		gap(n);
		chk("wd_fsys4", 1, n >= 32760 && n <= 32776);
		rst(32'h02E0_0000);
		gap(n);
		chk("wd_period", 1, n >= 16378 && n <= 16390);
		repeat (4000) @(posedge clk);
		ca <= 1;
		@(posedge clk);
		ca <= 0;
		gap(m);
		chk("wd_a_only", 1, m + 4001 >= 16376 && m + 4001 <= 16392);
		repeat (4000) @(posedge clk);
		ca <= 1;
		@(posedge clk);
		ca <= 0;
		cb <= 1;
		@(posedge clk);
		cb <= 0;
		gap(m);
		chk("wd_ab_clear", 1, m > 16300 && m < 16400);
		$display("t_wd done");
	endtask
	initial
	begin
		t_reg();
		t_uv();
		t_opt();
		t_wd();
		results();
	end
endmodule
`default_nettype wire
